// ===== design/cps_pkg.sv
// Purpose: Shared constants and types for the crystal position selector
// Assumes: 200 MHz mclk, all timing counted in milliseconds
// Notes: Times kept in seconds as printed, millisecond counts derived
package cps_pkg;

  // Clock and base time unit
  localparam int unsigned CPS_CLK_PERIOD_NS = 5;
  localparam int unsigned CPS_MS_NS = 1000000;
  localparam int unsigned CPS_CYC_PER_MS = CPS_MS_NS / CPS_CLK_PERIOD_NS;

  // Widths
  localparam int CPS_POS_W = 5;
  localparam int CPS_SEL_W = 30;
  localparam int CPS_MS_W = 14;
  localparam int CPS_HOLD_W = 3;

  // Positions and codes
  localparam logic [4:0] CPS_MAX_POS = 5'h1E;
  localparam logic [4:0] CPS_POS_RESET = 5'h01;
  localparam logic [4:0] CPS_CODE_LOW_UNUSED = 5'h1E;
  localparam logic [4:0] CPS_CODE_TOP_UNUSED = 5'h1F;

  // Single-step timing, seconds as printed
  localparam real CPS_STEP_ON_S = 1.5;
  localparam real CPS_STEP_OFF_S = 1.0;
  localparam logic [13:0] CPS_MS_PER_SEC = 14'h03E8;
  localparam logic [13:0] CPS_STEP_ON_MS =
    14'(int'(CPS_STEP_ON_S * 1000.0));
  localparam logic [13:0] CPS_STEP_OFF_MS =
    14'(int'(CPS_STEP_OFF_S * 1000.0));

  // Input hold time ceiling, seconds
  localparam logic [2:0] CPS_HOLD_MAX_S = 3'h5;

  // Position control modes
  typedef enum logic [2:0] {
    CPS_MANUAL, CPS_BIN0, CPS_BIN1, CPS_INDIV, CPS_DIRECT
  } cps_mode_t;

  // Direct drive types
  typedef enum logic [1:0] {CPS_UP, CPS_DOWN, CPS_STEP} cps_drive_t;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_RUN, ST_HALT, ST_SELECT, ST_DRIVE, ST_STEP_ON, ST_STEP_OFF
  } cps_state_t;

endpackage : cps_pkg

// ===== design/cps_settle_filter.sv
// Purpose: Accepts an input level only after it held steady long enough
// Assumes: rawIn synchronous to mclk, msTick one pulse per millisecond
// Notes: Any return to the accepted level restarts the hold count
`timescale 1ns/100ps
`default_nettype none
module cps_settle_filter #(
  parameter int MS_W = cps_pkg::CPS_MS_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Timing
  input wire logic msTick,
  input wire logic [MS_W-1:0] holdMs,
  // Signal
  input wire logic rawIn,
  output logic settled
);
  import cps_pkg::*;

  // Whole filter state
  typedef struct packed {
    logic settled;
    logic [MS_W-1:0] cnt;
  } cps_flt_t;

  cps_flt_t st; // Current state
  cps_flt_t next_st; // Next state

  // Count milliseconds the new level has held
  always_comb begin
    next_st = st;
    if (rawIn == st.settled) begin
      // Glitch ended, start over
      next_st.cnt = '0;
    end else if (st.cnt >= holdMs) begin
      next_st.settled = rawIn; // R11
      next_st.cnt = '0;
    end else if (msTick) begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign settled = st.settled;

  // A new level is taken only after the full hold time
  property p_settleHeld;
    @(posedge mclk) disable iff (rst)
      $changed(st.settled) |-> $past(st.cnt) >= $past(holdMs);
  endproperty
  a_settleHeld: assert property (p_settleHeld) // R11
    else $error("settled level changed before hold time");

  // Input equal to accepted level never flips the output
  property p_noFlipOnMatch;
    @(posedge mclk) disable iff (rst)
      (rawIn == settled) |=> (settled == $past(settled)) && st.cnt == '0;
  endproperty
  a_noFlipOnMatch: assert property (p_noFlipOnMatch) // R11
    else $error("settled level flipped with matching input");

endmodule : cps_settle_filter
`default_nettype wire

// ===== design/cps_crystal_selector.sv
// Purpose: Selects the crystal position of a multi-crystal sensor head
// Assumes: Inputs synchronous to mclk, posReached high when target sits
// Notes: Step on-time taken as 1.5 s; off-time is 1 s plus hold time
//
// Function
// R1: Manual mode halts after layer if position differs
// R2: Halt shows crystal number, resumes on start
// R3: Binary/individual modes drive enough selection outputs
// R4: Zero-based binary code is crystal minus one
// R5: One-based code equals crystal; zero means one
// R6: Logic one closes contact, zero opens it
// R7: Up/down motor held on until position reached
// R8: Single step pulses one output for 1.5 s
// R9: Step off time is 1 s plus hold
// R10: Drive type picks forward, reverse or both lines; no drive type here uses both lines
// R11: Inputs accepted only after steady hold time; only posReached goes through the hold filter
// R12: Individual mode closes only the target's output
`timescale 1ns/100ps
`default_nettype none
module cps_crystal_selector #(
  parameter int unsigned CYC_PER_MS = cps_pkg::CPS_CYC_PER_MS
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Configuration
  input wire cps_pkg::cps_mode_t ctrlMode,
  input wire cps_pkg::cps_drive_t driveType,
  input wire logic [cps_pkg::CPS_HOLD_W-1:0] holdTimeSec,
  // Process sequencing
  input wire logic layerDone,
  input wire logic [cps_pkg::CPS_POS_W-1:0] nextCrystal,
  input wire logic startCmd,
  output logic processHalt,
  output logic positionReady,
  output logic [cps_pkg::CPS_POS_W-1:0] requiredCrystal,
  // Position feedback
  input wire logic posReached,
  // Rotator outputs
  output logic [cps_pkg::CPS_SEL_W-1:0] selLines,
  output logic headAdvanceFwdLine,
  output logic headAdvanceRevLine
);
  import cps_pkg::*;

  // Whole selector state
  typedef struct packed {
    cps_state_t state;
    logic [CPS_POS_W-1:0] cur; // Position now in place
    logic [CPS_POS_W-1:0] tgt; // Position asked for
    logic [31:0] tickCnt; // Cycles within current millisecond
    logic [CPS_MS_W-1:0] msCnt; // Milliseconds in current state
    logic seenLow; // Feedback dropped since move began
    logic [CPS_SEL_W-1:0] sel;
    logic fwd;
    logic rev;
    logic halt;
    logic ready;
  } cps_top_t;

  cps_top_t st; // Current state
  cps_top_t next_st; // Next state

  logic tickWrap; // Last cycle of a millisecond
  logic posSettled; // Feedback after hold filter
  logic arrived; // Target confirmed in place
  logic [CPS_HOLD_W-1:0] holdSec; // Hold time clamped to range
  logic [CPS_MS_W-1:0] holdMs; // Hold time in milliseconds
  logic [CPS_MS_W-1:0] offMs; // Step off time in milliseconds
  logic [CPS_POS_W-1:0] reqPos; // Requested crystal, clamped

  // Out-of-range numbers fall back to crystal one
  function automatic logic [CPS_POS_W-1:0] clampPos(
    input logic [CPS_POS_W-1:0] p
  );
    logic [CPS_POS_W-1:0] r;
    r = p;
    if (p == '0 || p > CPS_MAX_POS) begin
      r = CPS_POS_RESET; // R5
    end
    return r;
  endfunction : clampPos

  // Contact pattern for a position, one bit closes a contact
  function automatic logic [CPS_SEL_W-1:0] encodeSel(
    input cps_mode_t m,
    input logic [CPS_POS_W-1:0] p
  );
    logic [CPS_SEL_W-1:0] v;
    v = '0;
    unique case (m)
      CPS_BIN0: begin
        v[CPS_POS_W-1:0] = p - 5'h01; // R4 R6
      end
      CPS_BIN1: begin
        v[CPS_POS_W-1:0] = p; // R5 R6
      end
      CPS_INDIV: begin
        v[p - 5'h01] = 1'b1; // R12 R3
      end
      CPS_MANUAL, CPS_DIRECT: begin
        v = '0;
      end
      default: begin
        // Illegal mode code keeps every contact open
        v = '0;
      end
    endcase
    return v;
  endfunction : encodeSel

  // Hold time feeds both the filter and the step off time
  always_comb begin
    holdSec = (holdTimeSec > CPS_HOLD_MAX_S) ? CPS_HOLD_MAX_S : holdTimeSec;
    holdMs = CPS_MS_W'(holdSec * CPS_MS_PER_SEC); // R11
    offMs = CPS_STEP_OFF_MS + holdMs; // R9
  end

  assign tickWrap = (st.tickCnt == 32'(CYC_PER_MS - 1));
  assign reqPos = clampPos(nextCrystal);
  // Stale high feedback from the old position must drop first
  assign arrived = posSettled && st.seenLow;

  // Feedback is trusted only once it held still for the hold time
  cps_settle_filter #(
    .MS_W(CPS_MS_W)
  ) u_posFilter (
    .mclk(mclk),
    .rst(rst),
    .msTick(tickWrap),
    .holdMs(holdMs),
    .rawIn(posReached),
    .settled(posSettled)
  );

  // Sequencer next state
  always_comb begin
    next_st = st;
    next_st.ready = 1'b0;
    // Millisecond timebase
    if (tickWrap) begin
      next_st.tickCnt = '0;
      next_st.msCnt = st.msCnt + 1'b1;
    end else begin
      next_st.tickCnt = st.tickCnt + 32'h1;
    end
    if (!posSettled) begin
      next_st.seenLow = 1'b1;
    end
    unique case (st.state)
      ST_RUN: begin
        // Layer boundary: see whether a move is needed
        if (layerDone) begin
          next_st.tgt = reqPos;
          next_st.tickCnt = '0;
          next_st.msCnt = '0;
          next_st.seenLow = !posSettled;
          if (reqPos == st.cur) begin
            next_st.ready = 1'b1;
          end else begin
            next_st.halt = 1'b1;
            unique case (ctrlMode)
              CPS_MANUAL: begin
                next_st.state = ST_HALT; // R1
              end
              CPS_BIN0, CPS_BIN1, CPS_INDIV: begin
                next_st.state = ST_SELECT; // R3
              end
              CPS_DIRECT: begin
                // Drive type decides which lines exist
                if (driveType == CPS_STEP) begin
                  next_st.state = ST_STEP_ON; // R8
                  next_st.fwd = 1'b1; // R10
                end else begin
                  next_st.state = ST_DRIVE; // R7
                  next_st.fwd = (driveType == CPS_UP); // R10
                  next_st.rev = (driveType == CPS_DOWN); // R10
                end
              end
              default: begin
                // Unknown mode: wait for the operator
                next_st.state = ST_HALT;
              end
            endcase
          end
        end
      end
      ST_HALT: begin
        // Operator changes the crystal, then presses start
        if (startCmd) begin
          next_st.state = ST_RUN; // R2
          next_st.cur = st.tgt;
          next_st.halt = 1'b0;
          next_st.ready = 1'b1;
        end
      end
      ST_SELECT, ST_DRIVE: begin
        // Contacts or motor stay on until target is confirmed
        if (arrived) begin
          next_st.state = ST_RUN; // R7
          next_st.cur = st.tgt;
          next_st.fwd = 1'b0;
          next_st.rev = 1'b0;
          next_st.halt = 1'b0;
          next_st.ready = 1'b1;
        end
      end
      ST_STEP_ON: begin
        // One solenoid pulse of fixed length
        if (tickWrap && st.msCnt == CPS_STEP_ON_MS - 14'h0001) begin
          next_st.state = ST_STEP_OFF; // R8
          next_st.fwd = 1'b0;
          next_st.tickCnt = '0;
          next_st.msCnt = '0;
        end
      end
      ST_STEP_OFF: begin
        // Pause long enough for feedback to settle before judging
        if (tickWrap && st.msCnt == offMs - 14'h0001) begin
          next_st.tickCnt = '0;
          next_st.msCnt = '0;
          if (arrived) begin
            next_st.state = ST_RUN;
            next_st.cur = st.tgt;
            next_st.halt = 1'b0;
            next_st.ready = 1'b1;
          end else begin
            next_st.state = ST_STEP_ON; // R9
            next_st.fwd = 1'b1;
          end
        end
      end
      default: begin
        next_st.state = ST_RUN;
      end
    endcase
    // Contacts always follow the target in the current mode
    next_st.sel = encodeSel(ctrlMode, next_st.tgt); // R3 R6
  end

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= '{state: ST_RUN, cur: CPS_POS_RESET, tgt: CPS_POS_RESET,
              tickCnt: 32'h0, msCnt: 14'h0000, seenLow: 1'b0,
              sel: 30'h0000_0000, fwd: 1'b0, rev: 1'b0, halt: 1'b0,
              ready: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state
  assign processHalt = st.halt;
  assign positionReady = st.ready;
  assign requiredCrystal = st.tgt; // R2
  assign selLines = st.sel;
  assign headAdvanceFwdLine = st.fwd;
  assign headAdvanceRevLine = st.rev;

  // Manual mode halts instead of moving
  property p_manualHalt;
    @(posedge mclk) disable iff (rst)
      (st.state == ST_RUN && layerDone && ctrlMode == CPS_MANUAL &&
       reqPos != st.cur) |=>
      (st.state == ST_HALT && processHalt && !headAdvanceFwdLine &&
       !headAdvanceRevLine);
  endproperty
  a_manualHalt: assert property (p_manualHalt) // R1
    else $error("manual mode did not halt on position change");

  // Halt holds the shown crystal until start
  sequence s_haltWait;
    st.state == ST_HALT && !startCmd;
  endsequence
  sequence s_haltStart;
    st.state == ST_HALT && startCmd;
  endsequence
  property p_haltStay;
    @(posedge mclk) disable iff (rst)
      s_haltWait |=> processHalt && requiredCrystal == $past(requiredCrystal);
  endproperty
  a_haltStay: assert property (p_haltStay) // R2
    else $error("halt left or crystal number changed without start");
  property p_haltResume;
    @(posedge mclk) disable iff (rst)
      s_haltStart |=> !processHalt && positionReady &&
        st.cur == $past(st.tgt);
  endproperty
  a_haltResume: assert property (p_haltResume) // R2
    else $error("start did not resume after halt");

  // Individual mode closes only the target contact
  property p_indivOneHot;
    @(posedge mclk) disable iff (rst)
      ctrlMode == CPS_INDIV |=>
        $onehot(selLines) && selLines[st.tgt - 5'h01];
  endproperty
  a_indivOneHot: assert property (p_indivOneHot) // R12
    else $error("individual contacts not one-hot on target");

  // Zero-based code is crystal minus one, top codes unused
  property p_binZero;
    @(posedge mclk) disable iff (rst)
      ctrlMode == CPS_BIN0 |=>
        selLines[4:0] == st.tgt - 5'h01 && selLines[29:5] == '0 &&
        selLines[4:0] != CPS_CODE_LOW_UNUSED &&
        selLines[4:0] != CPS_CODE_TOP_UNUSED;
  endproperty
  a_binZero: assert property (p_binZero) // R4
    else $error("zero-based binary code wrong");

  // One-based code equals crystal, all-ones never driven
  property p_binOne;
    @(posedge mclk) disable iff (rst)
      ctrlMode == CPS_BIN1 |=>
        selLines[4:0] == st.tgt && selLines[4:0] != CPS_CODE_TOP_UNUSED;
  endproperty
  a_binOne: assert property (p_binOne) // R5
    else $error("one-based binary code wrong");

  // Motor stays on while target not confirmed
  property p_driveHeld;
    @(posedge mclk) disable iff (rst)
      (st.state == ST_DRIVE && !arrived) |=>
        (headAdvanceFwdLine != headAdvanceRevLine);
  endproperty
  a_driveHeld: assert property (p_driveHeld) // R7
    else $error("motor output dropped before arrival");

  // Step pulse lasts exactly the on time
  property p_stepOn;
    @(posedge mclk) disable iff (rst)
      ($fell(headAdvanceFwdLine) && $past(st.state) == ST_STEP_ON) |->
        $past(st.msCnt) == CPS_STEP_ON_MS - 14'h0001 && $past(tickWrap);
  endproperty
  a_stepOn: assert property (p_stepOn) // R8
    else $error("step pulse length wrong");

  // Gap between step pulses is base off time plus hold
  property p_stepOff;
    @(posedge mclk) disable iff (rst)
      ($rose(headAdvanceFwdLine) && $past(st.state) == ST_STEP_OFF) |->
        $past(st.msCnt) == $past(offMs) - 14'h0001 && $past(tickWrap);
  endproperty
  a_stepOff: assert property (p_stepOff) // R9
    else $error("step off time wrong");

  // Reverse line only ever used by down drive
  property p_revOnlyDown;
    @(posedge mclk) disable iff (rst)
      headAdvanceRevLine |-> st.state == ST_DRIVE && !headAdvanceFwdLine;
  endproperty
  a_revOnlyDown: assert property (p_revOnlyDown) // R10
    else $error("reverse line active outside down drive");

endmodule : cps_crystal_selector
`default_nettype wire

// ===== tb/cps_rotator_model.sv
// Purpose: Behavioural crystal rotator on the far side of the selector
// Assumes: Selection contacts or drive lines from the selector
// Notes: Raises the in-position input a set delay after a new command; in step mode after the last needed pulse
`timescale 1ns/100ps
`default_nettype none
module cps_rotator_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Lines from the selector
  input wire logic [29:0] selLines,
  input wire logic fwdLine,
  input wire logic revLine,
  // Behaviour chosen by the bench
  input wire logic stepMode,
  input wire logic [2:0] stepsNeeded,
  input wire logic [15:0] delayCycles,
  // Feedback to the selector
  output logic posReached
);
  logic [29:0] lastSel; // Contacts one cycle ago
  logic lastFwd; // Forward line one cycle ago
  logic lastRev; // Reverse line one cycle ago
  logic busy; // Move under way
  logic counting; // Arrival countdown running
  logic [2:0] pulses; // Step pulses seen in this move
  logic [15:0] count; // Cycles left until arrival

  // Head leaves position on any new command, returns after the delay
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lastSel <= '0;
      lastFwd <= 1'b0;
      lastRev <= 1'b0;
      busy <= 1'b0;
      counting <= 1'b0;
      pulses <= '0;
      count <= '0;
      posReached <= 1'b1;
    end else begin
      lastSel <= selLines;
      lastFwd <= fwdLine;
      lastRev <= revLine;
      // Arrival once the countdown runs out
      if (counting) begin
        if (count == 16'h0000) begin
          posReached <= 1'b1;
          counting <= 1'b0;
          busy <= 1'b0;
        end else begin
          count <= count - 16'h0001;
        end
      end
      // Solenoid: one position per finished pulse
      if (stepMode) begin
        if (fwdLine && !lastFwd && !busy) begin
          busy <= 1'b1;
          posReached <= 1'b0;
          pulses <= '0;
        end
        if (!fwdLine && lastFwd && busy) begin
          pulses <= pulses + 3'h1;
          if (3'(pulses + 3'h1) == stepsNeeded) begin
            counting <= 1'b1;
            count <= delayCycles;
          end
        end
      end else if (selLines != lastSel || (fwdLine && !lastFwd) ||
                   (revLine && !lastRev)) begin
        // Stale high would fake arrival, so drop at once
        posReached <= 1'b0;
        counting <= 1'b1;
        count <= delayCycles;
        busy <= 1'b1;
      end
    end
  end
endmodule : cps_rotator_model
`default_nettype wire

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the crystal position selector
// Assumes: Millisecond parameter cut to 4 cycles, rotator model attached
// Notes: All expectations derived from the mode rules and that parameter
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import cps_pkg::*;
  localparam int unsigned CPM = 4; // Cycles per ms, shrunk for run time
  // Design ports
  logic mclk, rst, layerDone, startCmd, posReached;
  logic processHalt, positionReady, fwd, rev;
  cps_mode_t ctrlMode;
  cps_drive_t driveType;
  logic [2:0] holdTimeSec;
  logic [4:0] nextCrystal, requiredCrystal;
  logic [29:0] selLines;
  // Rotator model controls
  logic stepMode;
  logic [15:0] delayCycles;
  // Bookkeeping
  logic [4:0] cur; // Crystal the head sits on
  int fail_count, checked;

  cps_crystal_selector #(.CYC_PER_MS(CPM)) i_dut (.mclk(mclk), .rst(rst),
    .ctrlMode(ctrlMode), .driveType(driveType), .holdTimeSec(holdTimeSec),
    .layerDone(layerDone), .nextCrystal(nextCrystal), .startCmd(startCmd),
    .processHalt(processHalt), .positionReady(positionReady),
    .requiredCrystal(requiredCrystal), .posReached(posReached),
    .selLines(selLines), .headAdvanceFwdLine(fwd), .headAdvanceRevLine(rev));

  cps_rotator_model i_rot (.mclk(mclk), .rst(rst), .selLines(selLines),
    .fwdLine(fwd), .revLine(rev), .stepMode(stepMode),
    .stepsNeeded(3'h2), .delayCycles(delayCycles), .posReached(posReached));

  // Free running 200 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Shared compare, case equality so unknowns fail
  task automatic chk(input logic [29:0] got, input logic [29:0] exp,
                     input string m);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // Expected contacts for a mode and crystal
  function automatic logic [29:0] exp_sel(input cps_mode_t m,
                                          input logic [4:0] t);
    case (m)
      CPS_BIN0: exp_sel = 30'(t - 5'h01);
      CPS_BIN1: exp_sel = 30'(t);
      CPS_INDIV: exp_sel = 30'h00000001 << (t - 5'h01);
      default: exp_sel = 30'h00000000;
    endcase
  endfunction : exp_sel

  // Expected forward and reverse lines while a motor move runs
  function automatic logic [1:0] exp_drv();
    exp_drv = {ctrlMode == CPS_DIRECT && driveType == CPS_UP,
               ctrlMode == CPS_DIRECT && driveType == CPS_DOWN};
  endfunction : exp_drv

  // Layer completion pulse, returns where the answer has landed
  task automatic ask(input logic [4:0] c);
    @(posedge mclk);
    layerDone <= 1'b1;
    nextCrystal <= c;
    @(posedge mclk);
    layerDone <= 1'b0;
    // Look just after the taking edge, while the ready pulse stands
    #1;
  endtask : ask

  // One layer change with a powered move, n = cycles until ready
  task automatic move(input logic [4:0] c, output int n);
    logic [4:0] t;
    t = (c == 5'h00 || c > 5'h1E) ? 5'h01 : c;
    n = 0;
    ask(c);
    if (t == cur) begin
      chk({processHalt, positionReady}, 2'h1, "same crystal");
    end else begin
      chk(requiredCrystal, t, "target crystal");
      chk(selLines, exp_sel(ctrlMode, t), "contacts");
      // Bounded wait, line state checked every cycle
      while (positionReady !== 1'b1 && n < 20000) begin
        chk({processHalt, fwd, rev}, {1'b1, exp_drv()}, "moving");
        @(posedge mclk);
        #1;
        n++;
      end
      chk({processHalt, fwd, rev}, 3'h0, "arrived");
      chk(selLines, exp_sel(ctrlMode, t), "contacts kept");
      cur = t;
    end
  endtask : move

  // Idle state straight after reset
  task automatic test_reset;
    @(posedge mclk);
    #1;
    chk({processHalt, positionReady, fwd, rev}, 4'h0, "reset flags");
    chk(requiredCrystal, 5'h01, "reset crystal");
    chk(selLines, 30'h00000000, "reset contacts");
    cur = 5'h01;
  endtask : test_reset

  // Manual mode halts, shows the crystal and waits for start
  task automatic test_manual;
    int n;
    ask(5'h03);
    chk({processHalt, requiredCrystal}, {1'b1, 5'h03}, "halt");
    chk(selLines, 30'h00000000, "no contacts in manual");
    chk({fwd, rev}, 2'h0, "no drive in manual");
    repeat (50) @(posedge mclk);
    #1;
    chk({processHalt, positionReady}, 2'h2, "still halted");
    @(posedge mclk);
    startCmd <= 1'b1;
    @(posedge mclk);
    startCmd <= 1'b0;
    // Ready stands for the one cycle after the start is taken
    #1;
    chk({processHalt, positionReady}, 2'h1, "resumed");
    @(posedge mclk);
    #1;
    chk(positionReady, 1'b0, "ready one cycle");
    cur = 5'h03;
    move(5'h03, n);
  endtask : test_manual

  // Every crystal number through one contact mode, then code zero
  task automatic test_codes(input cps_mode_t m);
    int n;
    @(posedge mclk);
    ctrlMode <= m;
    repeat (20) @(posedge mclk);
    for (int i = 1; i <= 30; i++) begin
      move(5'(i), n);
    end
    move(5'h00, n);
  endtask : test_codes

  // Motor drive, prompt and slow with a one second hold
  task automatic test_direct;
    int n;
    @(posedge mclk);
    ctrlMode <= CPS_DIRECT;
    driveType <= CPS_UP;
    move(5'h0C, n);
    chk(30'(n < 50), 30'h1, "prompt arrival");
    @(posedge mclk);
    driveType <= CPS_DOWN;
    holdTimeSec <= 3'h1;
    delayCycles <= 16'h1388;
    move(5'h14, n);
    // Low then high must each hold 4000 cycles before counting
    chk(30'(n > 8900 && n < 9100), 30'h1, "settle time");
  endtask : test_direct

  // Solenoid stepping two positions with a one second hold
  task automatic test_step;
    int n;
    @(posedge mclk);
    driveType <= CPS_STEP;
    stepMode <= 1'b1;
    delayCycles <= 16'h0008;
    ask(5'h07);
    chk({processHalt, fwd, rev}, 3'h6, "pulse start");
    repeat (2) begin
      n = 0;
      while (fwd === 1'b1 && n < 7000) begin
        @(posedge mclk);
        #1;
        n++;
      end
      chk(30'(n), 30'(1500 * CPM), "pulse on time");
      n = 0;
      while (fwd === 1'b0 && positionReady !== 1'b1 && n < 9000) begin
        @(posedge mclk);
        #1;
        n++;
      end
      // Off time is one second plus the hold second
      chk(30'(n == 8000 || n == 8001), 30'h1, "pulse off time");
    end
    chk({processHalt, positionReady, rev}, 3'h2, "step arrival");
  endtask : test_step

  // Counts, verdict and end of run
  task automatic give_verdict;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  // Main sequence
  initial begin
    fail_count = 0;
    checked = 0;
    rst = 1'b1;
    ctrlMode = CPS_MANUAL;
    driveType = CPS_UP;
    holdTimeSec = 3'h0;
    layerDone = 1'b0;
    nextCrystal = 5'h01;
    startCmd = 1'b0;
    stepMode = 1'b0;
    delayCycles = 16'h0008;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    test_reset();
    test_manual();
    test_codes(CPS_BIN0);
    test_codes(CPS_BIN1);
    test_codes(CPS_INDIV);
    test_direct();
    test_step();
    give_verdict();
  end

  // Watchdog, well beyond the expected run of roughly 38500 cycles
  initial begin
    repeat (100000) @(posedge mclk);
    fail_count++;
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
